// ---- hw/hmw_mailbox.sv ----
// Purpose: Host byte window into controller memory plus mailboxes.
// Assumes: Both APB ports and the memory port run on clock_i.
// Notes:   Host data accesses that touch memory stretch the APB wait.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns

// Contract
// - Block idles to low power without software
// - Host inbound mailbox write signals the controller
// - Controller outbound mailbox write raises host event
// - Host reads event source, mask blocks each
// - Sixteen-bit address and 32-bit data register
// - Two regions reachable without controller help
// - Host bytes singly, memory transfers multi-byte
// - Base and limits only on controller side
// - Independent read and write limits per region
// - Each window spans at most 32 kilobytes
// - Data window stays four-byte aligned
// - Fifteen-bit offset from selected region base
// - Write outside writable area skips memory
// - Read in no-access area changes no memory or data
// - Out-of-bounds auto: reads advance, writes not
// - Two-bit selector picks 8/16/32/auto size
// - Auto mode byte three advances one doubleword
// - 32-bit: byte zero read loads all
// - 32-bit: byte three write stores all
// - 16-bit: bytes zero, two read load halves
// - 16-bit: bytes one, three write store halves
// - 8-bit: every byte access touches memory
// - Low two address bits act as zero
// - Receiving side may clear mailbox bits
// - Active-low host event follows pending events
module hmw_mailbox
  import hmw_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        h_psel_i,
  input  wire logic        h_penable_i,
  input  wire logic        h_pwrite_i,
  input  wire logic [7:0]  h_paddr_i,
  input  wire logic [31:0] h_pwdata_i,
  output logic      [31:0] h_prdata_o,
  output logic             h_pready_o,
  output logic             h_pslverr_o,
  input  wire logic        e_psel_i,
  input  wire logic        e_penable_i,
  input  wire logic        e_pwrite_i,
  input  wire logic [7:0]  e_paddr_i,
  input  wire logic [31:0] e_pwdata_i,
  output logic      [31:0] e_prdata_o,
  output logic             e_pready_o,
  output logic             e_pslverr_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output logic      [3:0]  mem_be_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic             ctl_mbox_event_o,
  output logic             host_event_n_o,
  output logic             low_power_o
);

  function automatic logic [3:0] lane_en(logic [1:0] a, logic [1:0] b);
    case (a)
      ACC_8:   lane_en = 4'h1 << b;
      ACC_16:  lane_en = b[1] ? 4'hc : 4'h3;
      default: lane_en = 4'hf;
    endcase
  endfunction

  function automatic logic load_at(logic [1:0] a, logic [1:0] b);
    case (a)
      ACC_8:   load_at = 1'h1;
      ACC_16:  load_at = ~b[0];
      default: load_at = (b == 2'h0);
    endcase
  endfunction

  function automatic logic store_at(logic [1:0] a, logic [1:0] b);
    case (a)
      ACC_8:   store_at = 1'h1;
      ACC_16:  store_at = b[0];
      default: store_at = (b == 2'h3);
    endcase
  endfunction

  function automatic logic [31:0] lanes(logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] put_byte(logic [31:0] d, logic [1:0] b,
                                           logic [7:0] v);
    logic [31:0] m;
    m = lanes(4'h1 << b);
    put_byte = (d & ~m) | ({4{v}} & m);
  endfunction

  hmw_state_t  state;
  logic [7:0]  inbound_mailbox;
  logic [7:0]  outbound_mailbox;
  logic [7:0]  app_id;
  logic [15:2] window_address;
  logic [1:0]  access_size;
  logic [31:0] data;
  logic [15:0] src;
  logic [15:0] mask;
  logic [31:2] base [2];
  logic [14:0] rd_lim [2];
  logic [14:0] wr_lim [2];
  logic [1:0]  p_b;
  logic        p_inc;

  logic [3:0]  h_idx;
  logic        h_map;
  logic        h_acc;
  logic        h_wr;
  logic        h_dat;
  logic [1:0]  h_b;
  logic        region;
  logic [14:0] offset;
  logic        rd_ok;
  logic        wr_ok;
  logic        go_rd;
  logic        go_wr;
  logic        auto_b3;
  logic [31:0] put_data;
  logic [31:0] rd_merge;
  logic [7:0]  h_rd_byte;
  logic        e_acc;
  logic        e_wr;
  logic        e_map;
  logic [31:0] e_rd;

  assign h_idx   = h_paddr_i[5:2];
  assign h_map   = (h_paddr_i[7:6] == 2'h0) && (h_idx <= HIDX_APP_ID);
  assign h_acc   = h_psel_i & h_penable_i & ~h_pready_o
                   & (state == ST_IDLE);
  assign h_wr    = h_acc & h_pwrite_i & h_map;
  assign h_dat   = h_acc & h_map & (h_idx >= HIDX_DATA0)
                   & (h_idx <= HIDX_DATA3);
  assign h_b     = h_idx[1:0];
  // Top address bit picks the region, the rest is the offset
  assign region  = window_address[REGION_SEL_BIT];
  assign offset  = {window_address[14:2], 2'h0};
  // Limits are in bytes, so a window never exceeds 32 KB
  assign rd_ok   = offset < rd_lim[region];
  assign wr_ok   = offset < wr_lim[region];
  assign go_rd   = h_dat & ~h_pwrite_i & load_at(access_size, h_b)
                   & rd_ok;
  assign go_wr   = h_dat & h_pwrite_i & store_at(access_size, h_b)
                   & wr_ok;
  // Reads of byte three always advance; writes only when in bounds
  assign auto_b3 = h_dat & (access_size == ACC_AUTO) & (h_b == 2'h3)
                   & (~h_pwrite_i | wr_ok);
  assign put_data = put_byte(data, h_b, h_pwdata_i[7:0]);
  assign rd_merge = (data & ~lanes(mem_be_o))
                    | (mem_rdata_i & lanes(mem_be_o));

  always_comb begin
    case (h_idx)
      HIDX_IN_MBOX:  h_rd_byte = inbound_mailbox;
      HIDX_OUT_MBOX: h_rd_byte = outbound_mailbox;
      HIDX_ADDR_LSB: h_rd_byte = {window_address[7:2], access_size};
      HIDX_ADDR_MSB: h_rd_byte = window_address[15:8];
      HIDX_SRC_LSB:  h_rd_byte = src[7:0];
      HIDX_SRC_MSB:  h_rd_byte = src[15:8];
      HIDX_MASK_LSB: h_rd_byte = mask[7:0];
      HIDX_MASK_MSB: h_rd_byte = mask[15:8];
      HIDX_APP_ID:   h_rd_byte = app_id;
      default:       h_rd_byte = data[8*h_b +: 8];
    endcase
    if (!h_map) begin
      h_rd_byte = 8'h00;
    end
  end

  // Host transfer sequencing and memory port
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state       <= ST_IDLE;
      h_pready_o  <= 1'h0;
      h_pslverr_o <= 1'h0;
      h_prdata_o  <= 32'h0000_0000;
      mem_req_o   <= 1'h0;
      mem_we_o    <= 1'h0;
      mem_addr_o  <= 32'h0000_0000;
      mem_be_o    <= 4'h0;
      mem_wdata_o <= 32'h0000_0000;
      p_b         <= 2'h0;
      p_inc       <= 1'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (h_acc && (go_rd || go_wr)) begin
            // No controller involvement: the block masters memory itself
            mem_req_o   <= 1'h1;
            mem_we_o    <= h_pwrite_i;
            mem_addr_o  <= {base[region], 2'h0}
                           + {17'h0_0000, offset};
            mem_be_o    <= lane_en(access_size, h_b);
            mem_wdata_o <= put_data;
            p_b         <= h_b;
            p_inc       <= auto_b3;
            state       <= ST_MEM;
          end else if (h_acc) begin
            h_pready_o  <= 1'h1;
            h_pslverr_o <= ~h_map;
            h_prdata_o  <= {24'h00_0000, h_rd_byte};
            state       <= ST_DONE;
          end
        end
        ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_o   <= 1'h0;
            h_pready_o  <= 1'h1;
            h_pslverr_o <= 1'h0;
            h_prdata_o  <= mem_we_o ? 32'h0000_0000
                           : {24'h00_0000, rd_merge[8*p_b +: 8]};
            state       <= ST_DONE;
          end
        end
        ST_DONE: begin
          h_pready_o  <= 1'h0;
          h_pslverr_o <= 1'h0;
          state       <= ST_IDLE;
        end
        default: begin
          h_pready_o  <= 1'h0;
          mem_req_o   <= 1'h0;
          state       <= ST_IDLE;
        end
      endcase
    end
  end

  // Data register: every host write to a data byte lands here
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data <= RST_DATA;
    end else if (h_dat && h_pwrite_i) begin
      data <= put_data;
    end else if (state == ST_MEM && mem_ack_i && !mem_we_o) begin
      data <= rd_merge;
    end
  end

  // Window address and access size
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      window_address <= RST_WADDR;
      access_size    <= RST_ACC;
    end else if (h_wr && h_idx == HIDX_ADDR_LSB) begin
      window_address[7:2] <= h_pwdata_i[7:2];
      access_size         <= h_pwdata_i[1:0];
    end else if (h_wr && h_idx == HIDX_ADDR_MSB) begin
      window_address[15:8] <= h_pwdata_i[7:0];
    end else if ((auto_b3 && !go_wr)
                 || (state == ST_MEM && mem_ack_i && p_inc)) begin
      window_address <= window_address + 14'h0001;
    end
  end

  // Mailboxes; a write from the sender wins over a clear
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inbound_mailbox  <= RST_MBOX;
      outbound_mailbox <= RST_MBOX;
      ctl_mbox_event_o <= 1'h0;
      app_id           <= RST_APP_ID;
    end else begin
      ctl_mbox_event_o <= h_wr && h_idx == HIDX_IN_MBOX;
      if (h_wr && h_idx == HIDX_IN_MBOX) begin
        inbound_mailbox <= h_pwdata_i[7:0];
      end else if (e_wr && e_paddr_i == EOFF_IN_MBOX) begin
        inbound_mailbox <= inbound_mailbox & ~e_pwdata_i[7:0];
      end
      if (e_wr && e_paddr_i == EOFF_OUT_MBOX) begin
        outbound_mailbox <= e_pwdata_i[7:0];
      end else if (h_wr && h_idx == HIDX_OUT_MBOX) begin
        outbound_mailbox <= outbound_mailbox & ~h_pwdata_i[7:0];
      end
      if (h_wr && h_idx == HIDX_APP_ID) begin
        app_id <= h_pwdata_i[7:0];
      end
    end
  end

  // Event source, mask and host event pin
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src            <= RST_SRC;
      mask           <= RST_MASK;
      host_event_n_o <= 1'h1;
    end else begin
      src <= (src & ~{(h_wr && h_idx == HIDX_SRC_MSB) ? h_pwdata_i[7:0]
                                                      : 8'h00,
                      (h_wr && h_idx == HIDX_SRC_LSB) ? h_pwdata_i[7:0]
                                                      : 8'h00})
             | {(e_wr && e_paddr_i == EOFF_SWI) ? e_pwdata_i[15:1]
                                                : 15'h0000,
                e_wr && e_paddr_i == EOFF_OUT_MBOX};
      if (h_wr && h_idx == HIDX_MASK_LSB) begin
        mask[7:0] <= h_pwdata_i[7:0];
      end
      if (h_wr && h_idx == HIDX_MASK_MSB) begin
        mask[15:8] <= h_pwdata_i[7:0];
      end
      host_event_n_o <= ~|(src & ~mask);
    end
  end

  // Controller-side APB slave; only place region settings live
  assign e_acc = e_psel_i & e_penable_i & ~e_pready_o;
  assign e_wr  = e_acc & e_pwrite_i & e_map;

  always_comb begin
    e_map = 1'h1;
    case (e_paddr_i)
      EOFF_IN_MBOX:  e_rd = {24'h00_0000, inbound_mailbox};
      EOFF_OUT_MBOX: e_rd = {24'h00_0000, outbound_mailbox};
      EOFF_R0_BASE:  e_rd = {base[0], 2'h0};
      EOFF_R0_LIM:   e_rd = {1'h0, rd_lim[0], 1'h0, wr_lim[0]};
      EOFF_R1_BASE:  e_rd = {base[1], 2'h0};
      EOFF_R1_LIM:   e_rd = {1'h0, rd_lim[1], 1'h0, wr_lim[1]};
      EOFF_SWI:      e_rd = {16'h0000, src};
      EOFF_STATUS:   e_rd = {16'h0000, window_address, access_size};
      default: begin
        e_rd  = 32'h0000_0000;
        e_map = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      e_pready_o  <= 1'h0;
      e_pslverr_o <= 1'h0;
      e_prdata_o  <= 32'h0000_0000;
      base[0]     <= RST_BASE;
      base[1]     <= RST_BASE;
      rd_lim[0]   <= RST_LIM;
      rd_lim[1]   <= RST_LIM;
      wr_lim[0]   <= RST_LIM;
      wr_lim[1]   <= RST_LIM;
    end else begin
      e_pready_o  <= e_acc;
      e_pslverr_o <= e_acc & ~e_map;
      e_prdata_o  <= (e_acc && !e_pwrite_i) ? e_rd : 32'h0000_0000;
      if (e_wr) begin
        case (e_paddr_i)
          EOFF_R0_BASE: base[0] <= e_pwdata_i[31:2];
          EOFF_R1_BASE: base[1] <= e_pwdata_i[31:2];
          EOFF_R0_LIM: begin
            rd_lim[0] <= e_pwdata_i[LIM_RD_LSB +: LIM_W];
            wr_lim[0] <= e_pwdata_i[LIM_WR_LSB +: LIM_W];
          end
          EOFF_R1_LIM: begin
            rd_lim[1] <= e_pwdata_i[LIM_RD_LSB +: LIM_W];
            wr_lim[1] <= e_pwdata_i[LIM_WR_LSB +: LIM_W];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Clock-gate hint: high the cycle after nothing addresses the block and the host sequencer is idle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_power_o <= 1'h0;
    end else begin
      low_power_o <= ~(h_psel_i | e_psel_i | (state != ST_IDLE));
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_inb_event;
    (h_wr && h_idx == HIDX_IN_MBOX) |=>
      ctl_mbox_event_o && inbound_mailbox == $past(h_pwdata_i[7:0]);
  endproperty
  a_inb_event: assert property (p_inb_event)
    else $error("inbound mailbox write gave no event");

  property p_out_event;
    (e_wr && e_paddr_i == EOFF_OUT_MBOX) |=> src[SRC_MBOX_BIT];
  endproperty
  a_out_event: assert property (p_out_event)
    else $error("outbound mailbox write did not set source");

  property p_evt_low;
    (|(src & ~mask)) |=> !host_event_n_o;
  endproperty
  a_evt_low: assert property (p_evt_low)
    else $error("pending event did not drive host event low");

  property p_evt_masked;
    ((src & ~mask) == 16'h0000) |=> host_event_n_o;
  endproperty
  a_evt_masked: assert property (p_evt_masked)
    else $error("masked event reached host event pin");

  property p_rd_noacc;
    (h_dat && !h_pwrite_i && !rd_ok) |=>
      !mem_req_o && data == $past(data) ##1 !h_pready_o;
  endproperty
  a_rd_noacc: assert property (p_rd_noacc)
    else $error("no-access read touched memory or data");

  property p_wr_ro;
    (h_dat && h_pwrite_i && !wr_ok) |=>
      !mem_req_o && data == $past(put_data);
  endproperty
  a_wr_ro: assert property (p_wr_ro)
    else $error("read-only write reached memory or missed data");

  property p_align;
    mem_req_o |-> mem_addr_o[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("memory address not doubleword aligned");

  property p_req_hold;
    (mem_req_o && !mem_ack_i) |=>
      mem_req_o && $stable(mem_addr_o) && $stable(mem_be_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before ack");

  property p_auto_rd;
    (h_dat && !h_pwrite_i && access_size == ACC_AUTO && h_b == 2'h3) |=>
      window_address == $past(window_address) + 14'h0001;
  endproperty
  a_auto_rd: assert property (p_auto_rd)
    else $error("auto read of byte three did not advance");

  property p_auto_wr_oob;
    (h_dat && h_pwrite_i && access_size == ACC_AUTO && h_b == 2'h3
     && !wr_ok) |=> $stable(window_address);
  endproperty
  a_auto_wr_oob: assert property (p_auto_wr_oob)
    else $error("out-of-bounds auto write advanced address");

  property p_rd32_held;
    (h_dat && !h_pwrite_i && access_size[1] && h_b != 2'h0) |=>
      !mem_req_o && h_pready_o;
  endproperty
  a_rd32_held: assert property (p_rd32_held)
    else $error("32-bit read of upper byte loaded memory");

  property p_pready_pulse;
    h_pready_o |=> !h_pready_o;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("host pready held beyond one cycle");

  property p_low_power;
    (!h_psel_i && !e_psel_i && state == ST_IDLE) |=> low_power_o;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("idle block not in low power");

  c_auto_inc: cover property (
    (state == ST_MEM && mem_ack_i && p_inc) ##1 h_pready_o);
  c_mem_read: cover property (mem_req_o && !mem_we_o && mem_ack_i);
  c_host_evt: cover property ($fell(host_event_n_o));

endmodule

// ---- shared/hmw_pkg.sv ----
// Purpose: Constants and types for the host memory window mailbox.
// Assumes: Host registers sit at word index times four on the host APB.
// Notes:   Controller-side offsets are byte addresses on the second APB.
package hmw_pkg;

  // Host window register indices, byte address is four times the index
  localparam logic [3:0] HIDX_IN_MBOX  = 4'h0;
  localparam logic [3:0] HIDX_OUT_MBOX = 4'h1;
  localparam logic [3:0] HIDX_ADDR_LSB = 4'h2;
  localparam logic [3:0] HIDX_ADDR_MSB = 4'h3;
  localparam logic [3:0] HIDX_DATA0    = 4'h4;
  localparam logic [3:0] HIDX_DATA3    = 4'h7;
  localparam logic [3:0] HIDX_SRC_LSB  = 4'h8;
  localparam logic [3:0] HIDX_SRC_MSB  = 4'h9;
  localparam logic [3:0] HIDX_MASK_LSB = 4'ha;
  localparam logic [3:0] HIDX_MASK_MSB = 4'hb;
  localparam logic [3:0] HIDX_APP_ID   = 4'hc;

  // Controller-side register byte offsets
  localparam logic [7:0] EOFF_IN_MBOX  = 8'h00;
  localparam logic [7:0] EOFF_OUT_MBOX = 8'h04;
  localparam logic [7:0] EOFF_R0_BASE  = 8'h08;
  localparam logic [7:0] EOFF_R0_LIM   = 8'h0c;
  localparam logic [7:0] EOFF_R1_BASE  = 8'h10;
  localparam logic [7:0] EOFF_R1_LIM   = 8'h14;
  localparam logic [7:0] EOFF_SWI      = 8'h18;
  localparam logic [7:0] EOFF_STATUS   = 8'h1c;

  // Access size selector codes
  localparam logic [1:0] ACC_8    = 2'h0;
  localparam logic [1:0] ACC_16   = 2'h1;
  localparam logic [1:0] ACC_32   = 2'h2;
  localparam logic [1:0] ACC_AUTO = 2'h3;

  // Field positions
  localparam int LIM_WR_LSB     = 0;
  localparam int LIM_RD_LSB     = 16;
  localparam int LIM_W          = 15;
  localparam int REGION_SEL_BIT = 15;
  localparam int SRC_MBOX_BIT   = 0;

  // Reset values
  localparam logic [7:0]  RST_MBOX   = 8'h00;
  localparam logic [7:0]  RST_APP_ID = 8'h00;
  localparam logic [13:0] RST_WADDR  = 14'h0000;
  localparam logic [1:0]  RST_ACC    = 2'h0;
  localparam logic [31:0] RST_DATA   = 32'h0000_0000;
  localparam logic [15:0] RST_SRC    = 16'h0000;
  localparam logic [15:0] RST_MASK   = 16'h0000;
  localparam logic [29:0] RST_BASE   = 30'h0000_0000;
  localparam logic [14:0] RST_LIM    = 15'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM  = 3'b010,
    ST_DONE = 3'b100
  } hmw_state_t;

endpackage

// ---- tb/tb_mem.sv ----
// Purpose: Behavioural controller memory behind the window port.
// Assumes: 256 words, word index from address bits 9:2.
// Notes:   Read data scrambles outside the ack cycle, as a real bus would.
`timescale 1ns/1ns
module tb_mem (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  lat_i,
  output logic             ack_o,
  output logic      [31:0] rdata_o,
  output int               count_o
);
  logic [31:0] ram [0:255];
  logic [3:0]  wait_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      count_o <= 0;
      rdata_o <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        if (wait_q != lat_i) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          ack_o <= 1'b1;
          wait_q <= 4'h0;
          count_o <= count_o + 1;
          rdata_o <= ram[addr_i[9:2]];
          for (int i = 0; i < 4; i++) begin
            if (we_i && be_i[i]) begin
              ram[addr_i[9:2]][8*i +: 8] <= wdata_i[8*i +: 8];
            end
          end
        end
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the host memory window mailbox.
// Assumes: Both register buses share address, direction and data lines.
// Notes:   Region 0 at 0x100, region 1 at 0x200 (write-only).
`timescale 1ns/1ns
module tb;
  import hmw_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        h_psel = 1'b0;
  logic        h_pen = 1'b0;
  logic        e_psel = 1'b0;
  logic        e_pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  lat = 4'h0;
  logic [31:0] rd, h_prdata_o, e_prdata_o, mem_addr_o, mem_wdata_o, mrd;
  logic        err, ev, lp, h_pready_o, h_pslverr_o, e_pready_o;
  logic        e_pslverr_o, mem_req_o, mem_we_o, mack, ctl_mbox_event_o;
  logic        host_event_n_o, low_power_o;
  logic [3:0]  mem_be_o;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;

  hmw_mailbox u_hmw_mailbox (.clock_i, .rst_b_i, .h_psel_i(h_psel),
    .h_penable_i(h_pen), .h_pwrite_i(pwr), .h_paddr_i(paddr),
    .h_pwdata_i(pwdata), .h_prdata_o, .h_pready_o, .h_pslverr_o,
    .e_psel_i(e_psel), .e_penable_i(e_pen), .e_pwrite_i(pwr),
    .e_paddr_i(paddr), .e_pwdata_i(pwdata), .e_prdata_o, .e_pready_o,
    .e_pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_be_o,
    .mem_wdata_o, .mem_ack_i(mack), .mem_rdata_i(mrd), .ctl_mbox_event_o,
    .host_event_n_o, .low_power_o);
  tb_mem u_tb_mem (.clock_i, .rst_b_i, .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o),
    .lat_i(lat), .ack_o(mack), .rdata_o(mrd), .count_o());

  always #5 clock_i = ~clock_i;

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input bit e, input bit w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    if (e) e_psel <= 1'b1;
    else h_psel <= 1'b1;
    @(posedge clock_i);
    if (e) e_pen <= 1'b1;
    else h_pen <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (!(e ? e_pready_o : h_pready_o) && n < 100);
    rd = e ? e_prdata_o : h_prdata_o;
    err = e ? e_pslverr_o : h_pslverr_o;
    ev = ctl_mbox_event_o;
    lp = low_power_o;
    if (n >= 100) fails++;
    e_psel <= 1'b0;
    e_pen <= 1'b0;
    h_psel <= 1'b0;
    h_pen <= 1'b0;
  endtask

  task automatic hwr(input logic [3:0] i, input logic [31:0] d);
    apb(1'b0, 1'b1, {2'b00, i, 2'b00}, d);
  endtask

  task automatic hrd(input logic [3:0] i, input logic [31:0] x);
    apb(1'b0, 1'b0, {2'b00, i, 2'b00}, 32'h0);
    chk("host read", x, rd);
  endtask

  task automatic t_misc;
    chk("idle", 1, low_power_o);
    hwr(4'hc, 8'h3c);
    chk("busy", 0, lp);
    hrd(4'hc, 8'h3c);
    apb(1'b0, 1'b0, 8'h34, 32'h0);
    chk("unmapped", 1, err);
    apb(1'b1, 1'b1, EOFF_R0_BASE, 32'h100);
    apb(1'b1, 1'b1, EOFF_R0_LIM, 32'h0040_0020);
    apb(1'b1, 1'b1, EOFF_R1_BASE, 32'h200);
    apb(1'b1, 1'b1, EOFF_R1_LIM, 32'h0000_0010);
    apb(1'b1, 1'b0, EOFF_R0_LIM, 32'h0);
    chk("limits", 32'h0040_0020, rd);
    apb(1'b1, 1'b0, 8'h40, 32'h0);
    chk("ctl unmapped", 1, err);
  endtask

  task automatic t_mbox;
    hwr(4'h0, 8'h5a);
    chk("doorbell", 1, ev);
    apb(1'b1, 1'b1, EOFF_IN_MBOX, 32'h0f);
    hrd(4'h0, 8'h50);
    apb(1'b1, 1'b0, EOFF_IN_MBOX, 32'h0);
    chk("ctl mailbox", 32'h50, rd);
  endtask

  task automatic t_event;
    apb(1'b1, 1'b1, EOFF_OUT_MBOX, 32'h81);
    repeat (2) @(posedge clock_i);
    chk("event", 0, host_event_n_o);
    hrd(4'h8, 8'h01);
    hwr(4'ha, 8'h01);
    repeat (2) @(posedge clock_i);
    chk("masked", 1, host_event_n_o);
    hwr(4'ha, 8'h00);
    hwr(4'h8, 8'h01);
    hrd(4'h1, 8'h81);
    hwr(4'h1, 8'h81);
    hrd(4'h1, 8'h00);
    apb(1'b1, 1'b1, EOFF_SWI, 32'h2);
    repeat (2) @(posedge clock_i);
    chk("soft event", 0, host_event_n_o);
    hwr(4'h8, 8'h02);
    repeat (2) @(posedge clock_i);
    chk("cleared", 1, host_event_n_o);
  endtask

  task automatic t_sizes;
    int c;
    hwr(4'h2, 8'h06);
    hwr(4'h3, 8'h00);
    c = u_tb_mem.count_o;
    hwr(4'h4, 8'h11);
    hwr(4'h5, 8'h22);
    hwr(4'h6, 8'h33);
    chk("no store", c, u_tb_mem.count_o);
    hwr(4'h7, 8'h44);
    chk("word", 32'h44332211, u_tb_mem.ram[8'h41]);
    hrd(4'h2, 8'h06);
    u_tb_mem.ram[8'h41] = 32'haabbccdd;
    hrd(4'h4, 8'hdd);
    hrd(4'h5, 8'hcc);
    hwr(4'h2, 8'h05);
    u_tb_mem.ram[8'h41] = 32'h12345678;
    hrd(4'h6, 8'h34);
    hrd(4'h7, 8'h12);
    hwr(4'h5, 8'h9a);
    hwr(4'h4, 8'h01);
    chk("half", 32'h12349add, u_tb_mem.ram[8'h41]);
    chk("loads", c + 4, u_tb_mem.count_o);
    hwr(4'h2, 8'h04);
    hwr(4'h6, 8'h55);
    hrd(4'h7, 8'h12);
    chk("byte", 32'h12559add, u_tb_mem.ram[8'h41]);
    lat <= 4'h3;
    u_tb_mem.ram[8'h81] = 32'h0;
    hwr(4'h3, 8'h80);
    hwr(4'h4, 8'hee);
    chk("region 1", 32'hee, u_tb_mem.ram[8'h81]);
    // Write-only region: a load would bring back zero
    u_tb_mem.ram[8'h81] = 32'h0;
    hrd(4'h4, 8'hee);
    hwr(4'h3, 8'h00);
    lat <= 4'h0;
  endtask

  task automatic t_auto;
    int c;
    hwr(4'h2, 8'h07);
    hrd(4'h7, 8'h12);
    hrd(4'h2, 8'h0b);
    hwr(4'h7, 8'h77);
    chk("auto", 32'h77559aee, u_tb_mem.ram[8'h42]);
    hrd(4'h2, 8'h0f);
    hwr(4'h2, 8'h43);
    c = u_tb_mem.count_o;
    hwr(4'h7, 8'h66);
    hrd(4'h2, 8'h43);
    hrd(4'h7, 8'h66);
    hrd(4'h2, 8'h47);
    hrd(4'h4, 8'hee);
    chk("no access", c, u_tb_mem.count_o);
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_misc();
    t_mbox();
    t_event();
    t_sizes();
    t_auto();
    final_report();
  end
endmodule
